// >>> core/contactless_wired_relay_buffer.sv
// Relay buffer between a wireless reader-writer and a wired host.
`timescale 1ns/100ps
`default_nettype none
`include "relay_defines.svh"
module contactless_wired_relay_buffer #(
	parameter int RAM_BYTES = `RELAY_RAM_BYTES
) (
	input wire logic sys_clk_in, // System clock, 10 MHz.
	input wire logic rst_in, // Synchronous reset, active high.
	input wire logic rf_cmd_valid_in, // Parsed wireless command strobe.
	input wire relay_pkg::rf_cmd_t rf_cmd_in, // Parsed wireless command.
	input wire logic rf_wdata_valid_in, // Wireless write byte valid.
	input wire logic [7:0] rf_wdata_in, // Wireless write byte.
	output logic rf_wdata_ready_out, // Wireless write byte taken.
	output logic rf_rsp_valid_out, // Wireless response strobe.
	output relay_pkg::rsp_t rf_rsp_out, // Wireless response status flags.
	output logic rf_pass_out, // Command left to the rest of the tag.
	output logic rf_rx_enable_out, // Wireless reception enabled.
	output logic relay_ready_n_pin_out, // Relay data waiting, active low.
	input wire logic host_cmd_valid_in, // Wired command strobe.
	input wire logic [7:0] host_cmd_in, // Wired command code.
	input wire logic [7:0] frame_size_byte_in, // Wired frame size byte.
	input wire logic host_wdata_valid_in, // Host return byte valid.
	input wire logic [7:0] host_wdata_in, // Host return byte.
	output logic host_wdata_ready_out, // Host return byte taken.
	output logic host_ans_valid_out, // Wired answer strobe.
	output logic [7:0] host_ans_status_out, // Wired answer status.
	output logic out_valid_out, // Outgoing data byte valid.
	output relay_pkg::out_word_t out_word_out, // Outgoing data byte.
	input wire logic out_ready_in // Outgoing data byte taken.
);
	// ----------------------------------------------------------------
	// Storage and state
	// ----------------------------------------------------------------
	logic [7:0] ram_ff [RAM_BYTES];
	relay_pkg::state_t state_ff;
	logic [7:0] cnt_ff;
	logic [7:0] tot_ff;
	logic [7:0] fill_ff;
	logic filled_ff;
	logic fetched_ff;
	logic [7:0] req_bytes;
	logic [7:0] ret_bytes;

	// ----------------------------------------------------------------
	// Block list checks
	// ----------------------------------------------------------------
	logic [11:0] access_bad;
	logic [11:0] order_bad;
	logic [11:0] hdr_bad;
	logic [11:0] in_rng;
	logic [11:0] out_rng;
	logic v_drop;
	logic v_err;
	logic v_foreign;
	relay_pkg::rsp_t v_flags;

	// Folds a twelve-element fault set onto the eight-bit bitmap.
	function automatic logic [7:0] fold_map(input logic [11:0] f);
		return f[7:0] | {4'h0, f[11:8]};
	endfunction

	// One checker for each possible element.
	for (genvar i = 0; i < `RELAY_NUM_ELEM; i++) begin : g_elem
		relay_elem_check u_chk (
			.elem_in(rf_cmd_in.elems[i]),
			.used_in(8'(i) < rf_cmd_in.blk_count),
			.access_bad_out(access_bad[i]),
			.order_bad_out(order_bad[i]),
			.hdr_bad_out(hdr_bad[i]),
			.in_range_out(in_rng[i]),
			.out_range_out(out_rng[i])
		);
	end

	// Verdict on a wireless command, in order of precedence.
	always_comb begin
		v_drop = 1'b0;
		v_err = 1'b1;
		v_foreign = 1'b0;
		v_flags = '{`FLAG_NONE, `FLAG_NONE};
		if (!rf_cmd_in.size_min_ok || !rf_cmd_in.card_id_ok) begin
			v_drop = 1'b1;
		end else if (rf_cmd_in.svc_count != `SVC_COUNT_ONE) begin
			v_flags = '{`FLAG_ALL, `ERR_SVC_COUNT};
		end else if (rf_cmd_in.blk_count == 8'h00 || rf_cmd_in.blk_count > `RELAY_MAX_BLK) begin
			v_flags = '{`FLAG_ALL, `ERR_BLK_COUNT};
		end else if (!rf_cmd_in.list_size_ok) begin
			v_drop = 1'b1;
		end else if (|access_bad) begin
			v_flags = '{fold_map(access_bad), `ERR_ACCESS};
		end else if (|order_bad) begin
			v_flags = '{fold_map(order_bad), `ERR_ORDER};
		end else if (!rf_cmd_in.svc_code_ok ||
			(rf_cmd_in.svc_attr != `SVC_ATTR_A && rf_cmd_in.svc_attr != `SVC_ATTR_B)) begin
			v_flags = '{`FLAG_SVC, `ERR_SVC};
		end else if (|hdr_bad) begin
			v_flags = '{fold_map(hdr_bad), `ERR_HDR};
		end else if (in_rng == 12'h000) begin
			v_err = 1'b0;
			v_foreign = 1'b1;
		end else if (out_rng != 12'h000) begin
			v_flags = '{fold_map(out_rng), `ERR_HDR};
		end else begin
			v_err = 1'b0;
		end
	end

	// Byte counts of a wireless request and of a host return.
	assign req_bytes = {rf_cmd_in.blk_count[3:0], 4'h0};
	assign ret_bytes = (frame_size_byte_in <= `FRAME_NO_DATA) ? 8'h00 :
		(frame_size_byte_in - `FRAME_NO_DATA > 8'(RAM_BYTES)) ? 8'(RAM_BYTES) :
		frame_size_byte_in - `FRAME_NO_DATA;

	// ----------------------------------------------------------------
	// Outgoing stream through the two-entry buffer
	// ----------------------------------------------------------------
	logic src_valid;
	logic src_ready;
	logic src_take;
	relay_pkg::out_word_t src_word;
	logic [7:0] rd_byte;

	// Stored bytes beyond the fill level, or any byte of an invalid buffer, read as zero.
	assign rd_byte = (filled_ff && cnt_ff < fill_ff) ? ram_ff[cnt_ff] : 8'h00;
	assign src_valid = (state_ff == relay_pkg::ST_RF_RD) || (state_ff == relay_pkg::ST_FETCH);
	assign src_word = '{state_ff == relay_pkg::ST_FETCH, cnt_ff == tot_ff - 8'h01, rd_byte};
	assign src_take = src_valid && src_ready;

	relay_out_fifo #(
		.WIDTH($bits(relay_pkg::out_word_t)),
		.DEPTH(2)
	) u_out (
		.sys_clk_in(sys_clk_in),
		.rst_in(rst_in),
		.in_valid_in(src_valid),
		.in_data_in(src_word),
		.in_ready_out(src_ready),
		.out_valid_out(out_valid_out),
		.out_data_out(out_word_out),
		.out_ready_in(out_ready_in)
	);

	// ----------------------------------------------------------------
	// Buffer writes
	// ----------------------------------------------------------------
	logic rf_take;
	logic host_take;

	assign rf_take = rf_wdata_valid_in && rf_wdata_ready_out;
	assign host_take = host_wdata_valid_in && host_wdata_ready_out;

	// Wireless block bytes or host return bytes land at the running count.
	always_ff @(posedge sys_clk_in) begin
		if (rf_take) begin
			ram_ff[cnt_ff] <= rf_wdata_in;
		end else if (host_take) begin
			ram_ff[cnt_ff] <= host_wdata_in;
		end
	end

	// ----------------------------------------------------------------
	// Control sequence
	// ----------------------------------------------------------------
	// Mode, counters, handshakes, pins and answers.
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			state_ff <= relay_pkg::ST_IDLE;
			cnt_ff <= 8'h00;
			tot_ff <= 8'h00;
			fill_ff <= 8'h00;
			filled_ff <= 1'b0;
			fetched_ff <= 1'b0;
			rf_wdata_ready_out <= 1'b0;
			host_wdata_ready_out <= 1'b0;
			rf_rsp_valid_out <= 1'b0;
			rf_rsp_out <= '0;
			rf_pass_out <= 1'b0;
			rf_rx_enable_out <= 1'b1;
			relay_ready_n_pin_out <= 1'b1;
			host_ans_valid_out <= 1'b0;
			host_ans_status_out <= `STR_DONE;
		end else begin
			rf_rsp_valid_out <= 1'b0;
			rf_pass_out <= 1'b0;
			host_ans_valid_out <= 1'b0;
			unique case (state_ff)
				relay_pkg::ST_IDLE: begin
					if (rf_cmd_valid_in && !v_drop) begin
						if (v_foreign) begin
							rf_pass_out <= 1'b1;
							filled_ff <= 1'b0;
						end else if (v_err) begin
							rf_rsp_valid_out <= 1'b1;
							rf_rsp_out <= v_flags;
						end else if (rf_cmd_in.is_read) begin
							rf_rsp_valid_out <= 1'b1;
							rf_rsp_out <= '{`FLAG_NONE, `FLAG_NONE};
							cnt_ff <= 8'h00;
							tot_ff <= req_bytes;
							state_ff <= relay_pkg::ST_RF_RD;
						end else begin
							filled_ff <= 1'b0;
							cnt_ff <= 8'h00;
							tot_ff <= req_bytes;
							rf_wdata_ready_out <= 1'b1;
							state_ff <= relay_pkg::ST_RF_WR;
						end
					end else if (host_cmd_valid_in) begin
						// Outside relay mode fetch and return are refused.
						if (host_cmd_in == `CMD_ARM_WRITE || host_cmd_in == `CMD_ARM_READ) begin
							filled_ff <= 1'b0;
							host_ans_valid_out <= 1'b1;
							host_ans_status_out <= `STR_DONE;
						end else if (host_cmd_in == `CMD_FETCH || host_cmd_in == `CMD_RETURN) begin
							host_ans_valid_out <= 1'b1;
							host_ans_status_out <= `STR_COND;
						end
					end
				end

				relay_pkg::ST_RF_WR: begin
					if (rf_take) begin
						cnt_ff <= cnt_ff + 8'h01;
						if (cnt_ff == tot_ff - 8'h01) begin
							fill_ff <= tot_ff;
							filled_ff <= 1'b1;
							fetched_ff <= 1'b0;
							rf_wdata_ready_out <= 1'b0;
							rf_rsp_valid_out <= 1'b1;
							rf_rsp_out <= '{`FLAG_NONE, `FLAG_NONE};
							relay_ready_n_pin_out <= 1'b0;
							rf_rx_enable_out <= 1'b0;
							state_ff <= relay_pkg::ST_RELAY;
						end
					end
				end

				relay_pkg::ST_RF_RD: begin
					if (src_take) begin
						cnt_ff <= cnt_ff + 8'h01;
						if (cnt_ff == tot_ff - 8'h01) begin
							state_ff <= relay_pkg::ST_IDLE;
						end
					end
				end

				relay_pkg::ST_RELAY: begin
					// Wireless commands are not looked at while here.
					if (host_cmd_valid_in) begin
						host_ans_valid_out <= 1'b1;
						host_ans_status_out <= `STR_DONE;
						if (host_cmd_in == `CMD_FETCH) begin
							cnt_ff <= 8'h00;
							tot_ff <= fill_ff;
							state_ff <= relay_pkg::ST_FETCH;
						end else if (host_cmd_in == `CMD_RETURN) begin
							cnt_ff <= 8'h00;
							tot_ff <= ret_bytes;
							filled_ff <= 1'b0;
							if (ret_bytes == 8'h00) begin
								host_ans_valid_out <= 1'b1;
								relay_ready_n_pin_out <= 1'b1;
								rf_rx_enable_out <= 1'b1;
								state_ff <= relay_pkg::ST_IDLE;
							end else begin
								host_ans_valid_out <= 1'b0;
								host_wdata_ready_out <= 1'b1;
								state_ff <= relay_pkg::ST_RETURN;
							end
						end else if (host_cmd_in == `CMD_ARM_WRITE || host_cmd_in == `CMD_ARM_READ) begin
							if (!fetched_ff) begin
								host_ans_status_out <= `STR_COND;
							end else begin
								filled_ff <= 1'b0;
							end
						end else begin
							host_ans_valid_out <= 1'b0;
						end
					end
				end

				relay_pkg::ST_FETCH: begin
					if (src_take) begin
						cnt_ff <= cnt_ff + 8'h01;
						if (cnt_ff == tot_ff - 8'h01) begin
							fetched_ff <= 1'b1;
							state_ff <= relay_pkg::ST_RELAY;
						end
					end
				end

				relay_pkg::ST_RETURN: begin
					if (host_take) begin
						cnt_ff <= cnt_ff + 8'h01;
						if (cnt_ff == tot_ff - 8'h01) begin
							fill_ff <= tot_ff;
							filled_ff <= 1'b1;
							host_wdata_ready_out <= 1'b0;
							host_ans_valid_out <= 1'b1;
							host_ans_status_out <= `STR_DONE;
							relay_ready_n_pin_out <= 1'b1;
							rf_rx_enable_out <= 1'b1;
							state_ff <= relay_pkg::ST_IDLE;
						end
					end
				end

				default: begin
					state_ff <= relay_pkg::ST_IDLE;
				end
			endcase
		end
	end
endmodule // contactless_wired_relay_buffer
`default_nettype wire

// >>> core/relay_defines.svh
// Constants of the relay buffer: block range, sizes, command codes and status codes.
`ifndef RELAY_DEFINES_SVH
`define RELAY_DEFINES_SVH
// ----------------------------------------------------------------
// Relay block range and buffer geometry
// ----------------------------------------------------------------
`define RELAY_BLK_LO 8'hB0
`define RELAY_BLK_HI 8'hBB
`define RELAY_MAX_BLK 8'h0C
`define RELAY_NUM_ELEM 12
`define RELAY_BLK_SHIFT 4
`define RELAY_RAM_BYTES 192
// ----------------------------------------------------------------
// Wired command codes and answer status
// ----------------------------------------------------------------
`define CMD_ARM_WRITE 8'h01
`define CMD_ARM_READ 8'h02
`define CMD_FETCH 8'h07
`define CMD_RETURN 8'h08
`define STR_DONE 8'h00
`define STR_COND 8'h04
`define FRAME_NO_DATA 8'h01
// ----------------------------------------------------------------
// Wireless status flag codes and field values
// ----------------------------------------------------------------
`define SVC_COUNT_ONE 8'h01
`define FLAG_ALL 8'hFF
`define FLAG_SVC 8'h01
`define FLAG_NONE 8'h00
`define ERR_SVC_COUNT 8'hA1
`define ERR_BLK_COUNT 8'hA2
`define ERR_ORDER 8'hA3
`define ERR_SVC 8'hA6
`define ERR_ACCESS 8'hA7
`define ERR_HDR 8'hA8
`define SVC_ATTR_A 6'h09
`define SVC_ATTR_B 6'h0B
`endif

// >>> core/relay_elem_check.sv
// Checks of one block list element.
`timescale 1ns/100ps
`default_nettype none
`include "relay_defines.svh"
module relay_elem_check (
	input wire relay_pkg::elem_t elem_in, // Element under test.
	input wire logic used_in, // Element lies within the block count.
	output logic access_bad_out, // Access mode not zero.
	output logic order_bad_out, // Service list order not zero.
	output logic hdr_bad_out, // Header bits not zero.
	output logic in_range_out, // Block number in the relay range.
	output logic out_range_out // Block number outside the relay range.
);
	logic in_rng;
	// Range test of the block number.
	assign in_rng = (elem_in.num >= `RELAY_BLK_LO) && (elem_in.num <= `RELAY_BLK_HI);
	// Field tests, masked by the element count.
	assign access_bad_out = used_in && (elem_in.access != 3'h0);
	assign order_bad_out = used_in && (elem_in.order != 4'h0);
	assign hdr_bad_out = used_in && (elem_in.hdr_bits != 2'h0);
	assign in_range_out = used_in && in_rng;
	assign out_range_out = used_in && !in_rng;
endmodule // relay_elem_check
`default_nettype wire

// >>> core/relay_out_fifo.sv
// Shifting output buffer whose head entry drives the outputs directly.
`timescale 1ns/100ps
`default_nettype none
module relay_out_fifo #(
	parameter int WIDTH = 10,
	parameter int DEPTH = 2
) (
	input wire logic sys_clk_in, // System clock.
	input wire logic rst_in, // Synchronous reset, active high.
	input wire logic in_valid_in, // Word offered.
	input wire logic [WIDTH-1:0] in_data_in, // Offered word.
	output logic in_ready_out, // Room for a word.
	output logic out_valid_out, // Head word valid.
	output logic [WIDTH-1:0] out_data_out, // Head word.
	input wire logic out_ready_in // Head word taken.
);
	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [DEPTH-1:0] vld_ff;
	logic pop;
	logic push;
	// Handshakes on both sides.
	assign pop = vld_ff[0] && out_ready_in;
	assign in_ready_out = !vld_ff[DEPTH-1];
	assign push = in_valid_in && in_ready_out;
	assign out_valid_out = vld_ff[0];
	assign out_data_out = mem_ff[0];
	// Occupancy: entries move down on a pop, a push fills the first free slot.
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			vld_ff <= '0;
		end else if (pop && !push) begin
			vld_ff <= {1'b0, vld_ff[DEPTH-1:1]};
		end else if (push && !pop) begin
			vld_ff <= {vld_ff[DEPTH-2:0], 1'b1};
		end
	end
	// Storage of the entries.
	always_ff @(posedge sys_clk_in) begin
		for (int k = 0; k < DEPTH; k++) begin
			if (push && (pop ? (k == DEPTH-1 || (vld_ff[k] && !vld_ff[k+1 < DEPTH ? k+1 : k])) ||
				(!vld_ff[0] && k == 0) : (!vld_ff[k] && (k == 0 || vld_ff[k > 0 ? k-1 : 0])))) begin
				mem_ff[k] <= in_data_in;
			end else if (pop && k < DEPTH-1) begin
				mem_ff[k] <= mem_ff[k < DEPTH-1 ? k+1 : k];
			end
		end
	end
endmodule // relay_out_fifo
`default_nettype wire

// >>> core/relay_pkg.sv
// Types shared by the relay buffer modules.
package relay_pkg;
	// Control states, Gray coded along write, relay, fetch, return.
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_RF_WR = 3'h1,
		ST_RELAY = 3'h3,
		ST_FETCH = 3'h2,
		ST_RETURN = 3'h6,
		ST_RF_RD = 3'h4
	} state_t;
	// One block list element as parsed by the wireless framer.
	typedef struct packed {
		logic [1:0] hdr_bits;
		logic [2:0] access;
		logic [3:0] order;
		logic [7:0] num;
	} elem_t;
	// One parsed wireless plain block read or write.
	typedef struct packed {
		logic is_read;
		logic size_min_ok;
		logic card_id_ok;
		logic list_size_ok;
		logic [7:0] svc_count;
		logic svc_code_ok;
		logic [5:0] svc_attr;
		logic [7:0] blk_count;
		elem_t [11:0] elems;
	} rf_cmd_t;
	// Wireless response status flags.
	typedef struct packed {
		logic [7:0] status_flag_one;
		logic [7:0] status_flag_two;
	} rsp_t;
	// One byte on the outgoing data stream.
	typedef struct packed {
		logic to_host;
		logic last;
		logic [7:0] data;
	} out_word_t;
endpackage

// >>> sim/contactless_wired_relay_buffer_bench.sv
// Self-checking bench of the relay buffer.
`timescale 1ns/100ps
`default_nettype none
module contactless_wired_relay_buffer_bench;
	logic sys_clk_in, rst_in, rf_cmd_valid_in, rf_wdata_valid_in, host_cmd_valid_in, host_wdata_valid_in, slow;
	logic rf_wdata_ready_out, rf_rsp_valid_out, rf_pass_out, rf_rx_enable_out, relay_ready_n_pin_out;
	logic host_wdata_ready_out, host_ans_valid_out, out_valid_out, out_ready_in;
	logic [7:0] rf_wdata_in, host_cmd_in, frame_size_byte_in, host_wdata_in, host_ans_status_out;
	relay_pkg::rf_cmd_t rf_cmd_in;
	relay_pkg::rsp_t rf_rsp_out;
	relay_pkg::out_word_t out_word_out;
	logic [7:0] exp_q[$];
	int mismatches = 0;
	int tests_run = 0;
	contactless_wired_relay_buffer i_contactless_wired_relay_buffer (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
		.rf_cmd_valid_in(rf_cmd_valid_in), .rf_cmd_in(rf_cmd_in), .rf_wdata_valid_in(rf_wdata_valid_in),
		.rf_wdata_in(rf_wdata_in), .rf_wdata_ready_out(rf_wdata_ready_out), .rf_rsp_valid_out(rf_rsp_valid_out),
		.rf_rsp_out(rf_rsp_out), .rf_pass_out(rf_pass_out), .rf_rx_enable_out(rf_rx_enable_out),
		.relay_ready_n_pin_out(relay_ready_n_pin_out), .host_cmd_valid_in(host_cmd_valid_in),
		.host_cmd_in(host_cmd_in), .frame_size_byte_in(frame_size_byte_in),
		.host_wdata_valid_in(host_wdata_valid_in), .host_wdata_in(host_wdata_in),
		.host_wdata_ready_out(host_wdata_ready_out), .host_ans_valid_out(host_ans_valid_out),
		.host_ans_status_out(host_ans_status_out), .out_valid_out(out_valid_out),
		.out_word_out(out_word_out), .out_ready_in(out_ready_in));
	relay_sink i_relay_sink (.sys_clk_in(sys_clk_in), .slow_in(slow), .valid_in(out_valid_out),
		.word_in(out_word_out), .ready_out(out_ready_in));
	// The clock runs at 10 MHz.
	initial begin
		sys_clk_in = 1'b0;
		forever #50 sys_clk_in = ~sys_clk_in;
	end
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic tick();
		@(posedge sys_clk_in);
		#1;
	endtask
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic test_done();
		$display("comparisons %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// Holds a byte until the ready flag is seen at a sampling edge.
	task automatic push(ref logic valid, ref logic [7:0] data, ref logic ready, input logic [7:0] b);
		logic ok;
		data = b;
		valid = 1'b1;
		ok = 1'b0;
		for (int t = 0; t < 40 && !ok; t++) begin
			ok = (ready === 1'b1);
			tick();
		end
		if (!ok) begin
			chk("byte handshake", 16'h0001, 16'h0000);
			test_done();
		end
	endtask
	function automatic relay_pkg::rf_cmd_t good(input logic rd, input logic [7:0] n);
		relay_pkg::rf_cmd_t c;
		c = '0;
		c.is_read = rd;
		c.size_min_ok = 1'b1;
		c.card_id_ok = 1'b1;
		c.list_size_ok = 1'b1;
		c.svc_count = 8'h01;
		c.svc_code_ok = 1'b1;
		c.svc_attr = rd ? 6'h0B : 6'h09;
		c.blk_count = n;
		for (int i = 0; i < 12; i++) c.elems[i].num = 8'hB2 - 8'(i % 3);
		return c;
	endfunction
	// Sends a command, then waits briefly for a response or pass-on pulse.
	task automatic rf_cmd(input relay_pkg::rf_cmd_t c, output logic got, output logic [15:0] flags);
		rf_cmd_in = c;
		rf_cmd_valid_in = 1'b1;
		tick();
		rf_cmd_valid_in = 1'b0;
		got = 1'b0;
		flags = 16'h0000;
		for (int i = 0; i < 5 && !got; i++) begin
			got = (rf_rsp_valid_out === 1'b1 || rf_pass_out === 1'b1);
			flags = rf_rsp_out;
			if (!got) tick();
		end
	endtask
	task automatic host(input logic [7:0] code, input logic [7:0] size, input logic [7:0] exp, input string what);
		logic [7:0] st;
		host_cmd_in = code;
		frame_size_byte_in = size;
		host_cmd_valid_in = 1'b1;
		tick();
		host_cmd_valid_in = 1'b0;
		for (int k = 0; k + 1 < size; k++) begin
			exp_q.push_back(8'(200 - k * 9));
			push(host_wdata_valid_in, host_wdata_in, host_wdata_ready_out, exp_q[k]);
		end
		host_wdata_valid_in = 1'b0;
		st = 8'hEE;
		for (int i = 0; i < 6 && st == 8'hEE; i++) begin
			if (host_ans_valid_out === 1'b1) st = host_ans_status_out;
			else tick();
		end
		chk(what, {8'h00, exp}, {8'h00, st});
		tick();
	endtask
	// Collects a stream and compares it with the expected bytes, zeros beyond them.
	task automatic drain(input int cnt, input logic toh);
		logic [7:0] d;
		for (int t = 0; t < cnt * 4 + 20 && i_relay_sink.got_q.size() < cnt; t++) tick();
		chk("stream length", 16'(cnt), 16'(i_relay_sink.got_q.size()));
		for (int k = 0; k < cnt && k < i_relay_sink.got_q.size(); k++) begin
			d = (k < exp_q.size()) ? exp_q[k] : 8'h00;
			chk("stream byte", {6'h00, toh, k == cnt - 1, d}, {6'h00, i_relay_sink.got_q[k]});
		end
		i_relay_sink.got_q.delete();
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_errors();
		relay_pkg::rf_cmd_t c;
		logic g;
		logic [15:0] f, e;
		for (int k = 0; k < 13; k++) begin
			c = good(k[0], 8'h0C);
			e = 16'h0000;
			case (k)
				0: c.size_min_ok = 1'b0;
				1: c.card_id_ok = 1'b0;
				2: c.list_size_ok = 1'b0;
				3: begin c.svc_count = 8'h02; e = 16'hFFA1; end
				4: begin c.blk_count = 8'h00; e = 16'hFFA2; end
				5: begin c.blk_count = 8'h0D; e = 16'hFFA2; end
				6: begin c.elems[8].access = 3'h1; e = 16'h01A7; end
				7: begin c.elems[4].order = 4'h1; e = 16'h10A3; end
				8: begin c.svc_code_ok = 1'b0; e = 16'h01A6; end
				9: begin c.svc_attr = 6'h0A; e = 16'h01A6; end
				10: begin c.elems[1].hdr_bits = 2'h1; e = 16'h02A8; end
				11: begin c.elems[11].num = 8'h10; e = 16'h08A8; end
				default: begin c.blk_count = 8'h01; c.elems[0].num = 8'h10; e = 16'h08A8; end
			endcase
			rf_cmd(c, g, f);
			chk("error answered", {15'h0000, k > 2}, {15'h0000, g});
			if (k > 2) chk("error flags", e, f);
			repeat (3) tick();
		end
	endtask
	task automatic t_write(input int n);
		logic g;
		logic [15:0] f;
		exp_q.delete();
		rf_cmd(good(1'b0, 8'(n)), g, f);
		for (int k = 0; k < n * 16; k++) begin
			exp_q.push_back(8'(k * 7 + 3));
			push(rf_wdata_valid_in, rf_wdata_in, rf_wdata_ready_out, exp_q[k]);
		end
		rf_wdata_valid_in = 1'b0;
		for (int i = 0; i < 5 && rf_rsp_valid_out !== 1'b1; i++) tick();
		chk("relay entry", 16'h0004, {13'h0000, rf_rsp_valid_out, relay_ready_n_pin_out, rf_rx_enable_out});
		chk("entry flags", 16'h0000, rf_rsp_out);
		tick();
		rf_cmd(good(1'b1, 8'h01), g, f);
		chk("relay silent", 16'h0000, {15'h0000, g});
	endtask
	task automatic t_read(input int n, input string what);
		logic g;
		logic [15:0] f;
		rf_cmd(good(1'b1, 8'(n)), g, f);
		chk(what, 16'h1000, {3'h0, g, f[11:0]});
		drain(n * 16, 1'b0);
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		{rst_in, rf_cmd_valid_in, rf_wdata_valid_in, host_cmd_valid_in, host_wdata_valid_in, slow} = 6'h20;
		{rf_wdata_in, host_cmd_in, frame_size_byte_in, host_wdata_in} = 32'h0000_0000;
		rf_cmd_in = '0;
		repeat (16) tick();
		rst_in = 1'b0;
		chk("reset pins", 16'h0003, {14'h0000, relay_ready_n_pin_out, rf_rx_enable_out});
		t_errors();
		t_write(12);
		host(8'h01, 8'h00, 8'h04, "early arm");
		slow = 1'b1;
		host(8'h07, 8'h00, 8'h00, "fetch");
		drain(192, 1'b1);
		slow = 1'b0;
		host(8'h02, 8'h00, 8'h00, "late arm");
		exp_q.delete();
		host(8'h08, 8'h05, 8'h00, "return data");
		chk("relay left", 16'h0003, {14'h0000, relay_ready_n_pin_out, rf_rx_enable_out});
		t_read(3, "padded read");
		host(8'h01, 8'h00, 8'h00, "idle arm");
		exp_q.delete();
		t_read(1, "invalid read");
		t_write(1);
		host(8'h07, 8'h00, 8'h00, "fetch one");
		drain(16, 1'b1);
		exp_q.delete();
		host(8'h08, 8'h01, 8'h00, "empty return");
		t_read(1, "empty read");
		test_done();
	end
endmodule // contactless_wired_relay_buffer_bench
`default_nettype wire

// >>> sim/relay_buffer_sva.sv
// Concurrent checks on the ports of the relay buffer.
`timescale 1ns/100ps
`default_nettype none
module relay_buffer_sva #(
	parameter int RAM_BYTES = 192
) (
	input wire logic sys_clk_in, // Clock.
	input wire logic rst_in, // Reset.
	input wire logic rf_cmd_valid_in, // Command strobe.
	input wire relay_pkg::rf_cmd_t rf_cmd_in, // Command.
	input wire logic rf_wdata_ready_out, // Write byte taken.
	input wire logic rf_rsp_valid_out, // Response strobe.
	input wire relay_pkg::rsp_t rf_rsp_out, // Response flags.
	input wire logic rf_pass_out, // Passed on.
	input wire logic rf_rx_enable_out, // Reception on.
	input wire logic relay_ready_n_pin_out, // Relay pin.
	input wire logic host_cmd_valid_in, // Host strobe.
	input wire logic [7:0] host_cmd_in, // Host code.
	input wire logic host_wdata_ready_out, // Host byte taken.
	input wire logic host_ans_valid_out, // Answer strobe.
	input wire logic [7:0] host_ans_status_out, // Answer status.
	input wire logic out_valid_out, // Stream valid.
	input wire relay_pkg::out_word_t out_word_out, // Stream word.
	input wire logic out_ready_in // Stream taken.
);
	// ----------------------------------------
	// Checks
	// ----------------------------------------
	// A command only counts while no stream is in flight.
	wire logic idle = rf_rx_enable_out && !rf_wdata_ready_out && !out_valid_out;
	wire logic hdr_ok = rf_cmd_valid_in && idle && rf_cmd_in.size_min_ok && rf_cmd_in.card_id_ok;
	wire logic busy = out_valid_out || host_wdata_ready_out;
	default clocking cb @(posedge sys_clk_in);
	endclocking
	default disable iff (rst_in);
	sequence s_enter;
		rf_rsp_valid_out && (rf_rsp_out == 16'h0000) && !rf_rx_enable_out;
	endsequence
	sequence s_done;
		host_ans_valid_out && (host_ans_status_out == 8'h00);
	endsequence
	chk_enter_relay: assert property ($fell(relay_ready_n_pin_out) |-> s_enter)
		else $error("relay entry without clean response");
	chk_pin_rx_tie: assert property (relay_ready_n_pin_out == rf_rx_enable_out)
		else $error("ready pin and reception disagree");
	chk_relay_silent: assert property (!relay_ready_n_pin_out && !$past(relay_ready_n_pin_out)
		|-> !rf_rsp_valid_out && !rf_pass_out)
		else $error("wireless answer in relay mode");
	chk_leave_relay: assert property (!$past(rst_in) && $rose(relay_ready_n_pin_out) |-> s_done)
		else $error("relay exit without answer");
	chk_svc_count: assert property (hdr_ok && rf_cmd_in.svc_count != 8'h01
		|-> ##[1:2] (rf_rsp_valid_out && rf_rsp_out == 16'hFFA1))
		else $error("service count error missing");
	chk_blk_count: assert property (hdr_ok && rf_cmd_in.svc_count == 8'h01
		&& (rf_cmd_in.blk_count == 8'h00 || rf_cmd_in.blk_count > 8'h0C)
		|-> ##[1:2] (rf_rsp_valid_out && rf_rsp_out == 16'hFFA2))
		else $error("block count error missing");
	chk_drop_bad: assert property (rf_cmd_valid_in && idle && !rf_cmd_in.card_id_ok
		|-> ##1 (!rf_rsp_valid_out && !rf_pass_out) [*2])
		else $error("bad identifier answered");
	chk_fetch_ans: assert property (host_cmd_valid_in && host_cmd_in == 8'h07 && !relay_ready_n_pin_out
		&& !busy |-> ##[1:2] s_done)
		else $error("fetch not answered");
	chk_stream_hold: assert property (out_valid_out && !out_ready_in |=> out_valid_out && $stable(out_word_out))
		else $error("stalled word changed");
endmodule // relay_buffer_sva
bind contactless_wired_relay_buffer relay_buffer_sva #(.RAM_BYTES(RAM_BYTES)) i_relay_buffer_sva (
	.sys_clk_in(sys_clk_in), .rst_in(rst_in), .rf_cmd_valid_in(rf_cmd_valid_in),
	.rf_cmd_in(rf_cmd_in), .rf_wdata_ready_out(rf_wdata_ready_out), .rf_rsp_valid_out(rf_rsp_valid_out),
	.rf_rsp_out(rf_rsp_out), .rf_pass_out(rf_pass_out), .rf_rx_enable_out(rf_rx_enable_out),
	.relay_ready_n_pin_out(relay_ready_n_pin_out), .host_cmd_valid_in(host_cmd_valid_in),
	.host_cmd_in(host_cmd_in), .host_wdata_ready_out(host_wdata_ready_out),
	.host_ans_valid_out(host_ans_valid_out), .host_ans_status_out(host_ans_status_out),
	.out_valid_out(out_valid_out), .out_word_out(out_word_out), .out_ready_in(out_ready_in)
);
`default_nettype wire

// >>> sim/relay_sink.sv
// Host side model that drains the outgoing byte stream.
`timescale 1ns/100ps
`default_nettype none
module relay_sink (
	input wire logic sys_clk_in, // Clock.
	input wire logic slow_in, // Stall on alternate cycles.
	input wire logic valid_in, // Byte offered.
	input wire relay_pkg::out_word_t word_in, // Offered byte.
	output logic ready_out // Byte taken.
);
	logic phase_ff = 1'b0;
	relay_pkg::out_word_t got_q[$];
	// The host collects every byte it accepts, stalling when asked to.
	always @(posedge sys_clk_in) begin
		phase_ff <= !phase_ff;
		if (valid_in && ready_out) begin
			got_q.push_back(word_in);
		end
	end
	assign ready_out = !slow_in || phase_ff;
endmodule // relay_sink
`default_nettype wire
